// *** rtl/pdi_pkg.sv ***
// Package: register map, field positions and constants of the decoder input front end
package pdi_pkg;

   // ----------------------------------------
   // Register byte offsets (AHB word aligned)
   // ----------------------------------------
   localparam logic [7:0] PDI_OFF_CONTROL_A     = 8'h00;  // Enable, reset, pin fields
   localparam logic [7:0] PDI_OFF_CONTROL_B_SET = 8'h04;  // Command field
   localparam logic [7:0] PDI_OFF_EVENT_CONTROL = 8'h08;  // Event source and invert
   localparam logic [7:0] PDI_OFF_PRESCALER     = 8'h0C;  // Prescaler select
   localparam logic [7:0] PDI_OFF_FILTER        = 8'h10;  // Filter length
   localparam logic [7:0] PDI_OFF_STATUS        = 8'h14;  // Run state and inputs
   localparam logic [7:0] PDI_OFF_DEBUG_CONTROL = 8'h18;  // Survives soft reset

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int PDI_BIT_SOFT_RESET   = 0;   // control_a
   localparam int PDI_BIT_ENABLE       = 1;   // control_a
   localparam int PDI_BIT_COUNT_EVENTS = 2;   // control_a
   localparam int PDI_POS_PIN_EN       = 8;   // control_a, three bits
   localparam int PDI_POS_PIN_INV      = 12;  // control_a, three bits
   localparam int PDI_POS_EVT_EN       = 0;   // event_control, three bits
   localparam int PDI_POS_EVT_INV      = 4;   // event_control, three bits
   localparam int PDI_POS_CMD          = 5;   // control_b_set, three bits

   // ----------------------------------------
   // Sizes, commands, reset values
   // ----------------------------------------
   localparam int         PDI_NUM_INPUTS = 3;
   localparam logic [2:0] PDI_CMD_NONE   = 3'h0;
   localparam logic [2:0] PDI_CMD_START  = 3'h1;
   localparam logic [2:0] PDI_CMD_STOP   = 3'h2;
   localparam logic [3:0] PDI_PRESCALER_SELECT_MAX  = 4'hA;   // Divide by 1024
   localparam logic [3:0] PDI_PRESCALER_SELECT_RST  = 4'h0;
   localparam logic [7:0] PDI_FILTER_RST = 8'h00;

   // Decoder run state, Gray coded along idle -> running -> stopping
   typedef enum logic [1:0] {
      PDI_ST_IDLE = 2'b00,
      PDI_ST_RUN  = 2'b01,
      PDI_ST_STOP = 2'b11
   } pdi_state_t;

endpackage

// *** rtl/pdi_input_filter.sv ***
// Module: one-input minimum duration filter clocked by a sample enable
`timescale 1ns/10ps
module pdi_input_filter (
   // ----- Clock and reset -----
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       clear,        // Soft reset, synchronous
   // ----- Sampling -----
   input  wire logic       sample,       // Filter tick
   input  wire logic [7:0] length,       // Required stable samples
   input  wire logic       raw_in,       // Conditioned input
   // ----- Result -----
   output logic            filt_out      // Filtered level
);
   import pdi_pkg::*;

   // All state in one struct
   typedef struct packed {
      logic       level;   // Current filtered level
      logic [7:0] count;   // Stable sample count
   } pdi_filt_t;

   pdi_filt_t cur;          // Registered state
   pdi_filt_t next_cur;     // Next state

   // ----------------------------------------
   // Count stable samples of a new level
   // ----------------------------------------
   always_comb begin
      next_cur = cur;
      if (clear) begin
         next_cur = '0;
      end else if (length == 8'h00) begin
         // Zero length: pass straight through
         next_cur.level = raw_in;
         next_cur.count = 8'h00;
      end else if (raw_in == cur.level) begin
         next_cur.count = 8'h00;
      end else if (sample) begin
         if (cur.count + 8'h01 >= length) begin
            next_cur.level = raw_in;
            next_cur.count = 8'h00;
         end else begin
            next_cur.count = cur.count + 8'h01;
         end
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign filt_out = cur.level;

endmodule

// *** rtl/pdi_front_end.sv ***
// Module: position decoder control, prescaler and input conditioning with AHB-Lite registers
// Bus answers with no wait states and an OKAY response.
// Reads are registered: the word is picked in the address phase
// and stands on hrdata from the data phase until the next read.
// Software should clear the enable bit before a soft reset; the
// block does not guard against a reset while decoding.
// Inputs are taken as synchronous to hclk; an asynchronous pin
// needs a synchroniser ahead of this block.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module pdi_front_end (
   // ----- Clock and reset -----
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ----- AHB-Lite slave -----
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // ----- Decoder inputs -----
   input  wire logic [2:0]  pin_in,        // Dedicated pins
   input  wire logic [2:0]  event_in,      // Event channels
   // ----- To decoding logic -----
   output logic [2:0]       decode_in,     // Filtered, selected inputs
   output logic             count_tick,    // Counter clock pulse
   output logic             update_now,    // Counter update strobe
   output logic             decoding,      // Decoding running
   output logic             enabled,       // Peripheral enabled
   // ----- Counter side request -----
   input  wire logic        update_req     // Counter update condition
);
   import pdi_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   // All registered state but the filters' in one word: bus shadow, control fields,
   // run state and prescaler. Hardware reset clears it all; soft
   // reset keeps debug control and the bus phase bits, so a
   // transfer in flight still completes.
   typedef struct packed {
      logic              enable;       // Peripheral enable
      logic              count_events; // Count events mode
      logic [2:0]        pin_en;       // Pin source enables
      logic [2:0]        pin_inv;      // Pin inversion
      logic [2:0]        evt_en;       // Event source enables
      logic [2:0]        evt_inv;      // Event inversion
      logic [3:0]        prescaler_select;        // Prescaler select
      logic [7:0]        filter;       // Filter length
      logic [7:0]        debug;        // Debug control, kept on soft reset
      pdi_state_t        state;        // Decoding state
      logic [9:0]        div;          // Prescaler counter
      logic              upd_pend;     // Update waiting for a tick
      logic              dph;          // Write data phase pending
      logic              dread;        // Read data phase pending
      logic [7:0]        daddr;        // Latched address
      logic [31:0]       rdata;        // Read data register
      logic              tick;         // Registered counter tick
   } pdi_regs_t;

   pdi_regs_t cur;        // Registered state
   pdi_regs_t next_cur;   // Next state

   // Helper nets between the sections below
   logic [2:0] cond_in;      // Selected, inverted inputs
   logic [2:0] filt_in;      // Filter outputs
   logic       soft_clear;   // Soft reset this cycle
   logic       prescaler_select_tick;   // Prescaled pulse
   logic       prescaler_select_run;    // Prescaler clocked
   logic       addr_ok;      // Address phase valid
   logic [9:0] div_mask;     // Prescaler terminal mask

   // ----------------------------------------
   // Per input: source, polarity and filter
   // ----------------------------------------
   // Pin wins when both enables set; neither selected reads low.
   // Inversion sits ahead of the filter, so the filter works on the
   // active level and its length means the same for either polarity.
   // Filter samples on the generic clock: duration is filter times period.
   genvar g;
   generate
      for (g = 0; g < PDI_NUM_INPUTS; g++) begin : gen_filt
         // Source select and polarity
         assign cond_in[g] = cur.pin_en[g] ? (pin_in[g] ^ cur.pin_inv[g])
                           : cur.evt_en[g] ? (event_in[g] ^ cur.evt_inv[g])
                           : 1'b0;
         // Minimum duration filter
         pdi_input_filter u_filt (
            .hclk     (hclk),
            .hresetn  (hresetn),
            .clear    (soft_clear),
            .sample   (1'b1),
            .length   (cur.filter),
            .raw_in   (cond_in[g]),
            .filt_out (filt_in[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Prescaler
   // ----------------------------------------
   // Free running up counter; a divide by 2^n pulse comes whenever its
   // low n bits are all ones. A ratio change on the fly may shorten the
   // first period, never stretch it past the new ratio. With nothing to
   // clock the counter is held at zero so an idle block toggles nothing.
   // Running while enabled and decoding, or whenever filtering is set
   assign prescaler_select_run  = (cur.enable && cur.state == PDI_ST_RUN)
                       || (cur.filter != PDI_FILTER_RST);
   // Mask of ones for divide by 2^prescaler_select; values above max clamp
   assign div_mask   = (cur.prescaler_select > PDI_PRESCALER_SELECT_MAX) ? 10'h3FF
                       : 10'((11'h001 << cur.prescaler_select) - 11'h001);
   assign prescaler_select_tick = prescaler_select_run && ((cur.div & div_mask) == div_mask);
   // Soft reset also empties the filters: a level held from before
   // the reset would otherwise leak into the decoder later
   assign soft_clear = cur.dph && (cur.daddr == PDI_OFF_CONTROL_A)
                       && hwdata[PDI_BIT_SOFT_RESET];
   assign addr_ok    = hsel && hready && htrans[1];

   // ----------------------------------------
   // Next state: bus, control, prescaler
   // ----------------------------------------
   // One process works out every next value. Later statements win,
   // so the soft reset block comes last and overrides any write or
   // counter step of the same cycle.
   always_comb begin
      logic [31:0] wd;
      logic        sr;
      wd = hwdata;
      sr = 1'b0;
      next_cur = cur;
      next_cur.dph   = 1'b0;
      next_cur.dread = 1'b0;
      // Address phase capture; the data phase follows on the next
      // edge because the slave is always ready
      if (addr_ok) begin
         next_cur.daddr = haddr[7:0];
         next_cur.dph   = hwrite;
         next_cur.dread = !hwrite;
      end
      // Prescaler counter
      if (prescaler_select_run) begin
         next_cur.div = cur.div + 10'h001;
      end else begin
         next_cur.div = 10'h000;
      end

      // Stop settles to idle after one cycle; a run without the enable
      // falls back to idle. This sits ahead of the register writes so
      // that a start written right after a stop is not lost.
      case (cur.state)
         PDI_ST_STOP: next_cur.state = PDI_ST_IDLE;
         PDI_ST_RUN: begin
            if (!cur.enable) begin
               next_cur.state = PDI_ST_IDLE;
            end
         end
         PDI_ST_IDLE: ;                           // Waits for a start
         default:     next_cur.state = PDI_ST_IDLE;
      endcase
      // Write data phase
      if (cur.dph) begin
         case (cur.daddr)
            PDI_OFF_CONTROL_A: begin
               // A soft reset write applies none of its other fields
               if (wd[PDI_BIT_SOFT_RESET]) begin
                  sr = 1'b1;
               end else begin
                  next_cur.enable       = wd[PDI_BIT_ENABLE];
                  next_cur.count_events = wd[PDI_BIT_COUNT_EVENTS];
                  next_cur.pin_en  = wd[PDI_POS_PIN_EN +: 3];
                  next_cur.pin_inv = wd[PDI_POS_PIN_INV +: 3];
                  if (!wd[PDI_BIT_ENABLE]) begin
                     next_cur.state = PDI_ST_IDLE;
                  end
               end
            end
            PDI_OFF_CONTROL_B_SET: begin
               // Start acts only while enabled; stop is always taken
               if (cur.enable && wd[PDI_POS_CMD +: 3] == PDI_CMD_START) begin
                  next_cur.state = PDI_ST_RUN;
               end else if (wd[PDI_POS_CMD +: 3] == PDI_CMD_STOP) begin
                  next_cur.state = PDI_ST_STOP;
               end
            end
            PDI_OFF_EVENT_CONTROL: begin
               // Event sources and their polarity
               next_cur.evt_en  = wd[PDI_POS_EVT_EN +: 3];
               next_cur.evt_inv = wd[PDI_POS_EVT_INV +: 3];
            end
            // Values above the top are kept as written and clamp in use
            PDI_OFF_PRESCALER: next_cur.prescaler_select  = wd[3:0];
            PDI_OFF_FILTER:    next_cur.filter = wd[7:0];
            PDI_OFF_DEBUG_CONTROL: next_cur.debug = wd[7:0];
            default: ;   // Unmapped writes ignored
         endcase
      end

      // Update deferred to the next prescaled pulse at divide by four and up, unless counting events. A
      // request that meets a pulse is served by it, so nothing is left
      // pending; a pulse alone serves whatever was waiting.
      if (prescaler_select_tick) begin
         next_cur.upd_pend = 1'b0;
      end else if (update_req && cur.prescaler_select > 4'h1 && !cur.count_events) begin
         next_cur.upd_pend = 1'b1;
      end

      // Counter clock: every cycle while running on events, else the
      // prescaled pulse
      next_cur.tick = cur.count_events ? (cur.state == PDI_ST_RUN)
                                       : prescaler_select_tick;

      // Read word picked in the address phase and registered, so it
      // stands on hrdata through the data phase. Control B set is a
      // command port and reads back as zero.
      if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            PDI_OFF_CONTROL_A: next_cur.rdata = {16'h0000, 1'b0, cur.pin_inv, 1'b0,
                                  cur.pin_en, 5'h00, cur.count_events, cur.enable, 1'b0};
            PDI_OFF_EVENT_CONTROL: next_cur.rdata = {25'h0, cur.evt_inv, 1'b0,
                                  cur.evt_en};
            PDI_OFF_PRESCALER: next_cur.rdata = {28'h0, cur.prescaler_select};
            PDI_OFF_FILTER:    next_cur.rdata = {24'h0, cur.filter};
            PDI_OFF_STATUS:    next_cur.rdata = {24'h0, 1'b0, filt_in, 1'b0,
                                  cur.upd_pend, cur.state};
            PDI_OFF_DEBUG_CONTROL: next_cur.rdata = {24'h0, cur.debug};
            default:           next_cur.rdata = 32'h0000_0000;
         endcase
      end

      // Soft reset: everything but debug control and bus phase.
      // Debug control is kept so settings made by a debug host
      // survive a soft reset issued by software.
      if (sr) begin
         next_cur.enable       = 1'b0;
         next_cur.count_events = 1'b0;
         next_cur.pin_en       = 3'h0;
         next_cur.pin_inv      = 3'h0;
         next_cur.evt_en       = 3'h0;
         next_cur.evt_inv      = 3'h0;
         next_cur.prescaler_select        = PDI_PRESCALER_SELECT_RST;
         next_cur.filter       = PDI_FILTER_RST;
         next_cur.state        = PDI_ST_IDLE;
         next_cur.div          = 10'h000;
         next_cur.upd_pend     = 1'b0;
         next_cur.tick         = 1'b0;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Hardware reset clears every field at once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Slave never stalls; response always OKAY. Every register is a
   // plain flop, so a wait state would buy nothing.
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign hrdata     = cur.rdata;
   assign decode_in  = filt_in;
   // Registered tick: one clock after the prescaler terminal count,
   // or high every cycle while running on events
   assign count_tick = cur.tick;
   assign decoding   = cur.state == PDI_ST_RUN;
   assign enabled    = cur.enable;
   // Immediate update at divide by one or two or while counting events, else on a tick.
   // The strobe is combinational: it meets prescaler_select_tick in its own
   // cycle, one cycle ahead of the registered count_tick.
   assign update_now = (cur.prescaler_select <= 4'h1 || cur.count_events) ? update_req
                       : (prescaler_select_tick && (cur.upd_pend || update_req));

endmodule

// *** bench/pdi_front_end_props.sv ***
// Checker: bus-snooped port relations of the decoder front end
`timescale 1ns/10ps
module pdi_front_end_props
   import pdi_pkg::*;
(
   // ----- Clock, reset, bus -----
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   // ----- Decoder side -----
   input wire logic        count_tick,
   input wire logic        update_now,
   input wire logic        decoding,
   input wire logic        enabled,
   input wire logic        update_req
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----------------------------------------
   // Shadow of the fields the relations need
   // ----------------------------------------
   logic       ap_wr;    // Write address phase seen
   logic [7:0] ap_adr;   // Its offset
   logic       cnt_ev;   // Count events mode
   logic [3:0] prescaler_select;    // Raw prescaler value
   logic       wr_a;
   logic       wr_b;
   logic       start_w;
   assign wr_a    = ap_wr && (ap_adr == PDI_OFF_CONTROL_A);
   assign wr_b    = ap_wr && (ap_adr == PDI_OFF_CONTROL_B_SET);
   assign start_w = wr_b && (hwdata[PDI_POS_CMD +: 3] == PDI_CMD_START);
   // Data phase follows the address phase by one edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr  <= 1'b0;
         ap_adr <= 8'h00;
         cnt_ev <= 1'b0;
         prescaler_select  <= PDI_PRESCALER_SELECT_RST;
      end else begin
         ap_wr  <= hsel && hready && htrans[1] && hwrite;
         ap_adr <= haddr[7:0];
         if (wr_a) begin
            cnt_ev <= hwdata[PDI_BIT_COUNT_EVENTS] && !hwdata[PDI_BIT_SOFT_RESET];
         end
         if (wr_a && hwdata[PDI_BIT_SOFT_RESET]) begin
            prescaler_select <= PDI_PRESCALER_SELECT_RST;
         end else if (ap_wr && ap_adr == PDI_OFF_PRESCALER) begin
            prescaler_select <= hwdata[3:0];
         end
      end
   end
   // ----------------------------------------
   // Relations
   // ----------------------------------------
   enable_follow_a: assert property (
      wr_a && !hwdata[0] |=> ##1 enabled == $past(hwdata[PDI_BIT_ENABLE], 2))
      else $error("enabled does not follow the control_a write");
   start_run_a: assert property (start_w && enabled |-> ##[1:3] decoding)
      else $error("start did not begin decoding");
   start_refused_a: assert property (start_w && !enabled && !decoding |=> !decoding)
      else $error("start accepted while disabled");
   no_early_run_a: assert property (
      $rose(decoding) |-> $past(start_w) || $past(start_w, 2))
      else $error("decoding began without start");
   stop_halt_a: assert property (
      wr_b && hwdata[PDI_POS_CMD +: 3] == PDI_CMD_STOP |-> ##[1:3] !decoding)
      else $error("stop did not halt decoding");
   soft_clear_a: assert property (wr_a && hwdata[0] |-> ##2 !enabled && !decoding)
      else $error("soft reset left the block active");
   events_bypass_a: assert property ((decoding && cnt_ev) [*3] |-> count_tick)
      else $error("event counting tick not every cycle");
   prescaler_select_gap_a: assert property (
      decoding && !cnt_ev && $past(prescaler_select, 2) == 4'h2 && prescaler_select == 4'h2 && count_tick
      |=> !count_tick [*3])
      else $error("divide by four tick came early");
   update_direct_a: assert property (
      update_req && decoding && prescaler_select <= 4'h1 |-> update_now)
      else $error("update not immediate at low prescaler");
endmodule

bind pdi_front_end pdi_front_end_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .count_tick, .update_now, .decoding, .enabled, .update_req);

// *** bench/pdi_encoder_model.sv ***
// Partner: quadrature encoder with index pulse on the three decoder pins
`timescale 1ns/10ps
module pdi_encoder_model (
   // ----- Clock -----
   input  wire logic       hclk,
   // ----- Bench control -----
   input  wire logic       step,   // Advance one quadrature edge
   input  wire logic       load,   // Force raw levels, restart count
   input  wire logic [2:0] level,  // Levels to force
   // ----- Sensor pins -----
   output logic      [2:0] pins    // Index, phase B, phase A
);
   logic [1:0] pos;  // Position in one Gray cycle
   initial begin
      pos  = 2'h0;
      pins = 3'h0;
   end
   // Only one phase moves per step, so a real encoder never skips a state
   always @(posedge hclk) begin
      if (load) begin
         pins <= level;
         pos  <= 2'h0;
      end else if (step) begin
         pos  <= pos + 2'h1;
         pins <= {pos == 2'h3, (pos + 2'h1) ^ ((pos + 2'h1) >> 1)};
      end
   end
endmodule

// *** bench/testbench.sv ***
// Testbench: control, prescaler, update timing, input selection and filtering
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
   import pdi_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, step, load, update_req, bad;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, event_in, level, pins, decode_in, pe, pi, ee, ei;
   logic        hrdy, hresp, count_tick, update_now, decoding, enabled;
   int          fails, tests_run, n, f;
   int          seed = 32'h9BAE;
   logic [3:0]  pl[13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 15};
   // 20 MHz bus clock
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   pdi_front_end uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hrdy), .hrdata, .hreadyout(hrdy), .hresp, .pin_in(pins), .event_in,
      .decode_in, .count_tick, .update_now, .decoding, .enabled, .update_req);
   pdi_encoder_model enc (.hclk, .step, .load, .level, .pins);
   // Single word transfer; read data lands in rd at the data phase edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hrdy !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   // Cycles between two count ticks, sampled mid-cycle
   task automatic gap(output int g);
      g = 0;
      @(negedge hclk);
      while (count_tick !== 1'b1 && g < 4000) begin @(negedge hclk); g++; end
      g = 0;
      do begin @(negedge hclk); g++; end while (count_tick !== 1'b1 && g < 4000);
   endtask
   // Pin wins over event; neither enabled gives low
   function automatic logic [2:0] sel_exp(logic [2:0] pe, pi, ee, ei, p, e);
      for (int i = 0; i < 3; i++) sel_exp[i] = pe[i] ? p[i] ^ pi[i] : ee[i] & (e[i] ^ ei[i]);
   endfunction
   task automatic force_pins(input logic [2:0] v);
      @(posedge hclk);
      load  <= 1'b1;
      level <= v;
      @(posedge hclk);
      load  <= 1'b0;
   endtask
   task automatic close_out;
      $display("TB: %0d checks, %0d mismatches", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Hang guard, well beyond the longest prescaler sweep
   initial begin
      repeat (60000) @(posedge hclk);
      fails++;
      close_out();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, step, load, level} = '0;
      {event_in, update_req, fails, tests_run} = '0;
      hsize = 3'h2;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      // Start while disabled is refused, then enable and start
      bus(PDI_OFF_CONTROL_B_SET, 1'b1, {24'h0, PDI_CMD_START, 5'h0});
      repeat (3) @(negedge hclk);
      `CHK("decoding", 1'b0, decoding)
      bus(PDI_OFF_CONTROL_A, 1'b1, 32'h2);
      repeat (2) @(negedge hclk);
      `CHK("enabled", 1'b1, enabled)
      bus(PDI_OFF_CONTROL_B_SET, 1'b1, {24'h0, PDI_CMD_START, 5'h0});
      repeat (3) @(negedge hclk);
      `CHK("decoding", 1'b1, decoding)
      // Every division ratio, plus two values past the top
      foreach (pl[i]) begin
         bus(PDI_OFF_PRESCALER, 1'b1, {28'h0, pl[i]});
         gap(n);
         gap(n);
         `CHK("tick gap", 1 << (pl[i] > 4'hA ? 10 : pl[i]), n)
      end
      // Update right after a tick: direct, or held to the next tick
      foreach (pl[i]) if (i < 4) begin
         bus(PDI_OFF_PRESCALER, 1'b1, {28'h0, pl[i]});
         gap(n);
         @(posedge hclk);
         update_req <= 1'b1;
         @(negedge hclk);
         `CHK("update now", pl[i] <= 4'h1, update_now)
         @(posedge hclk);
         update_req <= 1'b0;
         n = 0;
         do begin @(negedge hclk); n++; end
            while (pl[i] > 4'h1 && update_now !== 1'b1 && n < 16);
         `CHK("update wait", 1'b1, pl[i] <= 4'h1 || (update_now === 1'b1 && n < (1 << pl[i])))
      end
      // Event counting ignores the prescaler
      bus(PDI_OFF_CONTROL_A, 1'b1, 32'h6);
      repeat (3) @(negedge hclk);
      for (int k = 0; k < 6; k++) begin
         @(negedge hclk);
         `CHK("event tick", 1'b1, count_tick)
      end
      bus(PDI_OFF_CONTROL_B_SET, 1'b1, {24'h0, PDI_CMD_STOP, 5'h0});
      repeat (3) @(negedge hclk);
      `CHK("decoding", 1'b0, decoding)
      // Random source, polarity and level combinations
      repeat (12) begin
         {pe, pi, ee, ei, level} = $random(seed);
         bus(PDI_OFF_CONTROL_A, 1'b1, {17'h0, pi, 1'b0, pe, 8'h2});
         bus(PDI_OFF_EVENT_CONTROL, 1'b1, {25'h0, ei, 1'b0, ee});
         force_pins(level);
         event_in <= $random(seed);
         repeat (8) @(negedge hclk);
         `CHK("decode_in", sel_exp(pe, pi, ee, ei, pins, event_in), decode_in)
         bus(PDI_OFF_STATUS, 1'b0, 32'h0);
         `CHK("status in", sel_exp(pe, pi, ee, ei, pins, event_in), rd[6:4])
      end
      // Glitch shorter than the filter is dropped; a held level passes
      f = 4 + {$random(seed)} % 5;
      bus(PDI_OFF_CONTROL_A, 1'b1, 32'h702);
      bus(PDI_OFF_FILTER, 1'b1, f);
      // Stopped, yet filtering keeps the prescaler ticking
      gap(n);
      `CHK("filter clock", 1 << pl[3], n)
      force_pins(3'h0);
      repeat (f + 10) @(posedge hclk);
      force_pins(3'h7);
      repeat (f - 3) @(posedge hclk);
      force_pins(3'h0);
      bad = 1'b0;
      repeat (f + 6) @(negedge hclk) bad |= decode_in !== 3'h0;
      `CHK("glitch", 1'b0, bad)
      for (int k = 1; k < 6; k++) begin
         @(posedge hclk);
         step <= 1'b1;
         @(posedge hclk);
         step <= 1'b0;
         repeat (f + 10) @(negedge hclk);
         `CHK("quad", {k % 4 == 0, 2'((k % 4) ^ ((k % 4) >> 1))}, decode_in)
      end
      // Disable first, then soft reset; debug control survives
      bus(PDI_OFF_DEBUG_CONTROL, 1'b1, 32'h1);
      bus(PDI_OFF_CONTROL_A, 1'b1, 32'h0);
      bus(PDI_OFF_CONTROL_A, 1'b1, 32'h3);
      foreach (pl[i]) if (i < 4) begin
         bus(8'(i * 8), 1'b0, 32'h0);
         `CHK("after reset", i == 3 ? 32'h1 : 32'h0, rd)
      end
      bus(PDI_OFF_PRESCALER, 1'b0, 32'h0);
      `CHK("prescaler_select reset", {28'h0, PDI_PRESCALER_SELECT_RST}, rd)
      bus(8'h1C, 1'b0, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      `CHK("enabled", 1'b0, enabled)
      close_out();
   end
endmodule
